/* hw/pdcis_map.svh */
// pdcis_map.svh: register offsets, field positions, reset values and band limits
// assumes: included by bare name from the pll divider configuration design files
`ifndef PDCIS_MAP_SVH
`define PDCIS_MAP_SVH

// register offsets on the configuration port
`define PDCIS_OFF_FB_LOW_B0   8'h2a
`define PDCIS_OFF_IN1_B2      8'h2b
`define PDCIS_OFF_IN1_B1      8'h2c
`define PDCIS_OFF_IN1_B0      8'h2d
`define PDCIS_OFF_IN2_B2      8'h2e
`define PDCIS_OFF_IN2_B1      8'h2f
`define PDCIS_OFF_IN2_B0      8'h30
`define PDCIS_OFF_RATE        8'h37
`define PDCIS_OFF_STATUS      8'h80

// reset values
`define PDCIS_RST_FB_LOW_B0   8'hf9
`define PDCIS_RST_IN1_B2      8'h00
`define PDCIS_RST_IN1_B1      8'h00
`define PDCIS_RST_IN1_B0      8'h09
`define PDCIS_RST_IN2_B2      8'h00
`define PDCIS_RST_IN2_B1      8'h00
`define PDCIS_RST_IN2_B0      8'h00
`define PDCIS_RST_RATE        8'h00
`define PDCIS_RST_STATUS      8'h20

// writable bit masks, reserved bits stay zero
`define PDCIS_MASK_DIV_B2     8'h07
`define PDCIS_MASK_RATE       8'h3f

// field positions
`define PDCIS_RATE1_LSB       0
`define PDCIS_RATE2_LSB       3
`define PDCIS_ACT1_BIT        0
`define PDCIS_ACT2_BIT        1

// high-speed feedback code 0 means divide by 4, so counter setting = code + 3
`define PDCIS_FB_HIGH_OFFSET  20'h00003

// frequency bands per rate code, in MHz
`define PDCIS_BAND0_MIN       10'h00a
`define PDCIS_BAND0_MAX       10'h01b
`define PDCIS_BAND1_MIN       10'h019
`define PDCIS_BAND1_MAX       10'h036
`define PDCIS_BAND2_MIN       10'h032
`define PDCIS_BAND2_MAX       10'h069
`define PDCIS_BAND3_MIN       10'h05f
`define PDCIS_BAND3_MAX       10'h0d7
`define PDCIS_BAND4_MIN       10'h0be
`define PDCIS_BAND4_MAX       10'h1b3
`define PDCIS_BAND5_MIN       10'h177
`define PDCIS_BAND5_MAX       10'h2c6

`endif

/* hw/pdcis_pkg.sv */
// pdcis_pkg: shared types of the pll divider configuration block
// assumes: nothing beyond a SystemVerilog compiler
package pdcis_pkg;
    typedef logic [7:0]  pdcis_byte_t;
    typedef logic [19:0] pdcis_div_t;
    typedef logic [2:0]  pdcis_rate_t;
    typedef logic [9:0]  pdcis_mhz_t;
endpackage : pdcis_pkg

/* hw/pdcis_div_if.sv */
// pdcis_div_if: setting and event strobes between the top and one divider
// assumes: one clock domain, clk shared with the top
`timescale 1ns/100ps
interface pdcis_div_if;
    import pdcis_pkg::*;
    pdcis_div_t setting;
    logic       tick_in;
    logic       tick_out;
    modport cfg (output setting, output tick_in, input tick_out);
    modport div (input setting, input tick_in, output tick_out);
endinterface : pdcis_div_if

/* hw/pdcis_divider.sv */
// pdcis_divider: event divider, one output pulse per setting+1 input pulses
// assumes: tick_in is a one-cycle enable synchronous to clk
`timescale 1ns/100ps
module pdcis_divider (
    input  wire logic clk,
    input  wire logic rst,
    pdcis_div_if.div  dif
);
    import pdcis_pkg::*;

    pdcis_div_t cnt;
    logic       tick_out;
    logic       wrap;

    assign wrap         = (cnt >= dif.setting);
    assign dif.tick_out = tick_out;

    // count input events; wrap on reaching the setting, so ratio is setting + 1
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt      <= 20'h00000;
            tick_out <= 1'b0;
        end else begin
            tick_out <= dif.tick_in && wrap;
            if (dif.tick_in) begin
                cnt <= wrap ? 20'h00000 : cnt + 20'h00001;
            end
        end
    end

    AST_DIV_WRAP: assert property (@(posedge clk) disable iff (rst) // RULE4
        dif.tick_in && wrap |=> tick_out && cnt == 20'h00000)
        else $error("divider missed its output pulse");
    AST_DIV_CAUSE: assert property (@(posedge clk) disable iff (rst) // RULE1
        tick_out |-> $past(dif.tick_in))
        else $error("divider pulse without input event");
endmodule : pdcis_divider

/* hw/pdcis_top.sv */
// pdcis_top: pll divider settings, input rate bands and active-input status
// assumes: register port is the decoded side of the serial configuration port;
// clock inputs and feedback arrive as one-cycle event ticks on clk
//
// Notes on behaviour
// (RULE1) feedback low divider ratio equals its 20-bit setting plus one
// (RULE2) software writes only odd feedback low settings, giving even ratios
// (RULE3) feedback low divider byte 0 resets to 8'hf9
// (RULE4) input 1 divides by its 19-bit setting plus one; zero passes through
// (RULE5) input 1 divider byte 0 resets to 8'h09
// (RULE6) input 2 divides by its 19-bit setting plus one; zero passes through
// (RULE7) input 1 byte 2 and input 2 byte 1 reset to zero
// (RULE8) rate bits 5:3 belong to input 2, bits 2:0 to input 1
// (RULE9) rate codes 0..5 select bands 10-27 up to 375-710 MHz
// (RULE10) software never writes reserved rate codes 6 or 7
// (RULE11) status bit 0 is one when input 1 selected and without signal loss
// (RULE12) status bit 1 is one when input 2 selected and without signal loss
// (RULE13) status register reads 8'h20 after reset
// (RULE14) signal loss alarms are active high, zero in normal operation
// (RULE15) feedback high divider drives low divider; total ratio is the product
// (RULE16) reserved bits read zero and writes to them do nothing; the status register's upper reserved bits read the 8'h20 pattern instead
// (RULE17) multi-byte settings assemble high byte first into one value
`timescale 1ns/100ps
`include "pdcis_map.svh"
module pdcis_top (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire pdcis_pkg::pdcis_byte_t reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output pdcis_pkg::pdcis_byte_t    reg_rdata,
    input  wire logic [11:0]          feedback_low_divider_upper,
    input  wire logic [2:0]           feedback_high_divider,
    input  wire logic                 clock_input_one,
    input  wire logic                 clock_input_two,
    input  wire logic                 feedback_in,
    input  wire logic                 input1_selected,
    input  wire logic                 input2_selected,
    input  wire logic                 input1_signal_loss_alarm,
    input  wire logic                 input2_signal_loss_alarm,
    output logic                      input1_ref_tick,
    output logic                      input2_ref_tick,
    output logic                      feedback_tick,
    output pdcis_pkg::pdcis_rate_t    input1_rate_select,
    output pdcis_pkg::pdcis_rate_t    input2_rate_select,
    output pdcis_pkg::pdcis_mhz_t     input1_band_min,
    output pdcis_pkg::pdcis_mhz_t     input1_band_max,
    output pdcis_pkg::pdcis_mhz_t     input2_band_min,
    output pdcis_pkg::pdcis_mhz_t     input2_band_max,
    output logic                      input1_active_flag,
    output logic                      input2_active_flag
);
    import pdcis_pkg::*;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    pdcis_byte_t feedback_low_divider_byte0;
    pdcis_byte_t input1_divider_byte2;
    pdcis_byte_t input1_divider_byte1;
    pdcis_byte_t input1_divider_byte0;
    pdcis_byte_t input2_divider_byte2;
    pdcis_byte_t input2_divider_byte1;
    pdcis_byte_t input2_divider_byte0;
    pdcis_byte_t input_rate_select;
    pdcis_byte_t active_input_status;
    pdcis_byte_t next_status;
    pdcis_byte_t next_rdata;

    // writes land in the addressed byte; reserved bits are masked off
    always_ff @(posedge clk) begin
        if (rst) begin
            feedback_low_divider_byte0 <= `PDCIS_RST_FB_LOW_B0; // RULE3
            input1_divider_byte2       <= `PDCIS_RST_IN1_B2;    // RULE7
            input1_divider_byte1       <= `PDCIS_RST_IN1_B1;
            input1_divider_byte0       <= `PDCIS_RST_IN1_B0;    // RULE5
            input2_divider_byte2       <= `PDCIS_RST_IN2_B2;
            input2_divider_byte1       <= `PDCIS_RST_IN2_B1;    // RULE7
            input2_divider_byte0       <= `PDCIS_RST_IN2_B0;
            input_rate_select          <= `PDCIS_RST_RATE;
        end else if (reg_wr) begin
            case (reg_addr)
                `PDCIS_OFF_FB_LOW_B0: begin
                    feedback_low_divider_byte0 <= reg_wdata;
                end
                `PDCIS_OFF_IN1_B2: begin
                    input1_divider_byte2 <= reg_wdata & `PDCIS_MASK_DIV_B2; // RULE16
                end
                `PDCIS_OFF_IN1_B1: begin
                    input1_divider_byte1 <= reg_wdata;
                end
                `PDCIS_OFF_IN1_B0: begin
                    input1_divider_byte0 <= reg_wdata;
                end
                `PDCIS_OFF_IN2_B2: begin
                    input2_divider_byte2 <= reg_wdata & `PDCIS_MASK_DIV_B2; // RULE16
                end
                `PDCIS_OFF_IN2_B1: begin
                    input2_divider_byte1 <= reg_wdata;
                end
                `PDCIS_OFF_IN2_B0: begin
                    input2_divider_byte0 <= reg_wdata;
                end
                `PDCIS_OFF_RATE: begin
                    input_rate_select <= reg_wdata & `PDCIS_MASK_RATE; // RULE16
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // active input status
    // ------------------------------------------------------------
    // an input counts as active only while selected and its loss alarm is low
    always_comb begin
        next_status = `PDCIS_RST_STATUS;
        next_status[`PDCIS_ACT1_BIT] = input1_selected && !input1_signal_loss_alarm; // RULE11 RULE14
        next_status[`PDCIS_ACT2_BIT] = input2_selected && !input2_signal_loss_alarm; // RULE12 RULE14
    end

    // status register, read only; upper reserved pattern holds its reset value
    always_ff @(posedge clk) begin
        if (rst) begin
            active_input_status <= `PDCIS_RST_STATUS; // RULE13
            input1_active_flag  <= 1'b0;
            input2_active_flag  <= 1'b0;
        end else begin
            active_input_status <= next_status;
            input1_active_flag  <= next_status[`PDCIS_ACT1_BIT];
            input2_active_flag  <= next_status[`PDCIS_ACT2_BIT];
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // read mux; unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            `PDCIS_OFF_FB_LOW_B0: next_rdata = feedback_low_divider_byte0;
            `PDCIS_OFF_IN1_B2:    next_rdata = input1_divider_byte2;
            `PDCIS_OFF_IN1_B1:    next_rdata = input1_divider_byte1;
            `PDCIS_OFF_IN1_B0:    next_rdata = input1_divider_byte0;
            `PDCIS_OFF_IN2_B2:    next_rdata = input2_divider_byte2;
            `PDCIS_OFF_IN2_B1:    next_rdata = input2_divider_byte1;
            `PDCIS_OFF_IN2_B0:    next_rdata = input2_divider_byte0;
            `PDCIS_OFF_RATE:      next_rdata = input_rate_select;
            `PDCIS_OFF_STATUS:    next_rdata = active_input_status;
            default:              next_rdata = 8'h00;
        endcase
    end

    // read data is registered and holds until the next read
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // rate bands for the frequency offset monitor
    // ------------------------------------------------------------
    // code to band limits; reserved codes give an empty band
    function automatic pdcis_mhz_t band_limit(input pdcis_rate_t code, input logic want_max);
        pdcis_mhz_t lim;
        case (code)
            3'h0:    lim = want_max ? `PDCIS_BAND0_MAX : `PDCIS_BAND0_MIN;
            3'h1:    lim = want_max ? `PDCIS_BAND1_MAX : `PDCIS_BAND1_MIN;
            3'h2:    lim = want_max ? `PDCIS_BAND2_MAX : `PDCIS_BAND2_MIN;
            3'h3:    lim = want_max ? `PDCIS_BAND3_MAX : `PDCIS_BAND3_MIN;
            3'h4:    lim = want_max ? `PDCIS_BAND4_MAX : `PDCIS_BAND4_MIN;
            3'h5:    lim = want_max ? `PDCIS_BAND5_MAX : `PDCIS_BAND5_MIN;
            default: lim = 10'h000;
        endcase
        return lim;
    endfunction : band_limit

    pdcis_rate_t rate1;
    pdcis_rate_t rate2;
    assign rate1 = input_rate_select[`PDCIS_RATE1_LSB +: 3]; // RULE8
    assign rate2 = input_rate_select[`PDCIS_RATE2_LSB +: 3]; // RULE8

    // band outputs follow the rate register one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            input1_rate_select <= 3'h0;
            input2_rate_select <= 3'h0;
            input1_band_min    <= 10'h000;
            input1_band_max    <= 10'h000;
            input2_band_min    <= 10'h000;
            input2_band_max    <= 10'h000;
        end else begin
            input1_rate_select <= rate1;
            input2_rate_select <= rate2;
            input1_band_min    <= band_limit(rate1, 1'b0); // RULE9
            input1_band_max    <= band_limit(rate1, 1'b1); // RULE9
            input2_band_min    <= band_limit(rate2, 1'b0);
            input2_band_max    <= band_limit(rate2, 1'b1);
        end
    end

    // ------------------------------------------------------------
    // dividers: 0 input 1, 1 input 2, 2 feedback high, 3 feedback low
    // ------------------------------------------------------------
    pdcis_div_t div_set [4];
    logic [3:0] src_tick;
    logic [3:0] div_tick;
    pdcis_div_t fb_low_setting;

    // settings are assembled most significant byte first
    assign div_set[0] = {1'b0, input1_divider_byte2[2:0], input1_divider_byte1,
                         input1_divider_byte0}; // RULE4 RULE17
    assign div_set[1] = {1'b0, input2_divider_byte2[2:0], input2_divider_byte1,
                         input2_divider_byte0}; // RULE6 RULE17
    assign div_set[2] = {17'h00000, feedback_high_divider} + `PDCIS_FB_HIGH_OFFSET;
    assign fb_low_setting = {feedback_low_divider_upper, feedback_low_divider_byte0}; // RULE17
    assign div_set[3] = fb_low_setting; // RULE1

    // the high divider feeds the low one, so the ratios multiply
    assign src_tick = {div_tick[2], feedback_in, clock_input_two, clock_input_one}; // RULE15

    pdcis_div_if dif [4] ();

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_div
            assign dif[g].setting = div_set[g];
            assign dif[g].tick_in = src_tick[g];
            assign div_tick[g]    = dif[g].tick_out;
            pdcis_divider i_pdcis_divider (
                .clk (clk),
                .rst (rst),
                .dif (dif[g])
            );
        end
    endgenerate

    // divided ticks leave through one more register
    always_ff @(posedge clk) begin
        if (rst) begin
            input1_ref_tick <= 1'b0;
            input2_ref_tick <= 1'b0;
            feedback_tick   <= 1'b0;
        end else begin
            input1_ref_tick <= div_tick[0];
            input2_ref_tick <= div_tick[1];
            feedback_tick   <= div_tick[3];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_rate_write;
        reg_wr && reg_addr == `PDCIS_OFF_RATE;
    endsequence
    sequence s_code0_seen;
        rate1 == 3'h0 ##1 1'b1;
    endsequence

    AST_FB_RESET: assert property (@(posedge clk) // RULE3
        rst |=> feedback_low_divider_byte0 == 8'hf9)
        else $error("feedback byte 0 reset wrong");
    AST_IN1_RESET: assert property (@(posedge clk) // RULE5
        rst |=> input1_divider_byte0 == 8'h09)
        else $error("input 1 byte 0 reset wrong");
    AST_ZERO_RESET: assert property (@(posedge clk) // RULE7
        rst |=> input1_divider_byte2 == 8'h00 && input2_divider_byte1 == 8'h00)
        else $error("zero reset registers wrong");
    AST_STATUS_RESET: assert property (@(posedge clk) // RULE13
        rst |=> active_input_status == 8'h20)
        else $error("status reset wrong");
    AST_ACT1: assert property (@(posedge clk) disable iff (rst) // RULE11
        input1_selected && !input1_signal_loss_alarm |=> active_input_status[0]
        ##0 input1_active_flag)
        else $error("input 1 active flag not set");
    AST_ACT2: assert property (@(posedge clk) disable iff (rst) // RULE12
        input2_signal_loss_alarm |=> !active_input_status[1] && !input2_active_flag)
        else $error("input 2 active despite loss");
    AST_RATE_RSV: assert property (@(posedge clk) disable iff (rst) // RULE16
        s_rate_write |=> input_rate_select == (($past(reg_wdata)) & 8'h3f)
        ##1 input_rate_select[7:6] == 2'h0)
        else $error("rate write or reserved bits wrong");
    AST_BAND0: assert property (@(posedge clk) disable iff (rst) // RULE9
        s_code0_seen |-> input1_band_min == 10'h00a && input1_band_max == 10'h01b)
        else $error("rate code 0 band wrong");
    AST_IN2_SET: assert property (@(posedge clk) disable iff (rst) // RULE6
        clock_input_two && div_set[1] == 20'h00000 |=> div_tick[1])
        else $error("input 2 zero setting did not pass the tick");
    AST_FB_CHAIN: assert property (@(posedge clk) disable iff (rst) // RULE15
        div_tick[3] |-> $past(div_tick[2]))
        else $error("feedback low pulse without high pulse");
endmodule : pdcis_top

/* verif/pdcis_host_model.sv */
// pdcis_host_model: host side of the decoded register port
// assumes: strobes are sampled on the rising edge of clk, driven after falling edges
`timescale 1ns/100ps
module pdcis_host_model (
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    // idle port from time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one write, strobe held across exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(negedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;  // released data must not look held
    endtask : wr

    // one read, data is taken by the bench monitor
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(negedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;  // released address must not look held
    endtask : rd
endmodule : pdcis_host_model

/* verif/tb_pll_divider_config_and_input_status.sv */
// tb_pll_divider_config_and_input_status: self-checking bench of pdcis_top
// assumes: pdcis_pkg and the host model are compiled first
`timescale 1ns/100ps
module tb_pll_divider_config_and_input_status;
    import pdcis_pkg::*;
    logic        clk, rst, take, ck1, ck2, fbin, sel1, sel2, los1, los2;
    logic [7:0]  reg_addr, reg_wdata;
    logic        reg_wr, reg_rd, t1, t2, tf, act1, act2;
    logic [11:0] fb_upper;
    logic [2:0]  fb_high, c2;
    pdcis_byte_t reg_rdata;
    pdcis_rate_t r1, r2;
    pdcis_mhz_t  b1lo, b1hi, b2lo, b2hi;
    logic [7:0]  exp_q[$];
    logic [9:0]  bmin[6] = '{10'h00a, 10'h019, 10'h032, 10'h05f, 10'h0be, 10'h177};
    logic [9:0]  bmax[6] = '{10'h01b, 10'h036, 10'h069, 10'h0d7, 10'h1b3, 10'h2c6};
    logic [7:0]  ra[10]  = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h37, 8'h80, 8'h31};
    logic [7:0]  re[10]  = '{8'hf9, 8'h00, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
    int          fail_count, n_tests, n1, n2, nf, k, s, np;

    // ---------------------------------------------------------------
    // clock, design and host
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    pdcis_host_model i_pdcis_host_model (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    pdcis_top i_pdcis_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .feedback_low_divider_upper(fb_upper), .feedback_high_divider(fb_high),
        .clock_input_one(ck1), .clock_input_two(ck2), .feedback_in(fbin),
        .input1_selected(sel1), .input2_selected(sel2), .input1_signal_loss_alarm(los1),
        .input2_signal_loss_alarm(los2), .input1_ref_tick(t1), .input2_ref_tick(t2),
        .feedback_tick(tf), .input1_rate_select(r1), .input2_rate_select(r2),
        .input1_band_min(b1lo), .input1_band_max(b1hi), .input2_band_min(b2lo),
        .input2_band_max(b2hi), .input1_active_flag(act1), .input2_active_flag(act2));

    // ---------------------------------------------------------------
    // checking and reporting
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // read data shows right after the taking edge and is compared on the next falling edge; oldest note is compared
    always @(posedge clk) take <= reg_rd & ~rst;
    always @(negedge clk) begin
        if (take === 1'b1) begin
            if (exp_q.size() == 0)
                check("read without note", 20'h1, 20'h0);
            else
                check("reg_rdata", reg_rdata, exp_q.pop_front());
        end
    end

    // output ticks counted once each, away from the rising edge
    always @(negedge clk) begin
        n1 += (t1 === 1'b1);
        n2 += (t2 === 1'b1);
        nf += (tf === 1'b1);
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    // ---------------------------------------------------------------
    // stimulus helpers
    // ---------------------------------------------------------------
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_pdcis_host_model.rd(a);
    endtask : rd_exp

    task automatic reset_dut();
        @(negedge clk);
        rst <= 1'b1;
        repeat (16) @(negedge clk);
        rst <= 1'b0;
        @(posedge clk);
        n1 = 0;
        n2 = 0;
        nf = 0;
    endtask : reset_dut

    // back-to-back event ticks on the chosen inputs, then drain the pipeline
    task automatic pulses(input logic [2:0] msk, input int n);
        repeat (n) begin
            @(negedge clk);
            {ck2, ck1, fbin} <= msk;
        end
        @(negedge clk);
        {ck2, ck1, fbin} <= 3'b000;
        repeat (5) @(negedge clk);
        @(posedge clk);
    endtask : pulses

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {rst, ck1, ck2, fbin, sel1, sel2, los1, los2} = 8'hff;
        {ck1, ck2, fbin, sel1, sel2, los1, los2} = 7'h00;
        fb_upper = 12'h000;
        fb_high = 3'h0;
        fail_count = 0;
        n_tests = 0;
        void'($urandom(83));
        reset_dut();
        // reset values and an unmapped read
        for (int i = 0; i < 10; i++)
            rd_exp(ra[i], re[i]);
        $display("reset values done");
        // reserved bits, read-only status, unmapped write
        i_pdcis_host_model.wr(8'h2b, 8'hff);
        i_pdcis_host_model.wr(8'h2e, 8'hff);
        i_pdcis_host_model.wr(8'h37, 8'hff);
        i_pdcis_host_model.wr(8'h80, 8'h00);
        i_pdcis_host_model.wr(8'h31, 8'h55);
        rd_exp(8'h2b, 8'h07);
        rd_exp(8'h2e, 8'h07);
        rd_exp(8'h37, 8'h3f);
        rd_exp(8'h80, 8'h20);
        rd_exp(8'h31, 8'h00);
        check("rate1 reserved", r1, 20'h7);
        check("band1 reserved", b1hi, 20'h0);
        $display("reserved bits done");
        // every valid rate code on input 1, random valid code on input 2
        for (int c = 0; c < 6; c++) begin
            c2 = 3'($urandom_range(5, 0));
            i_pdcis_host_model.wr(8'h37, {2'b00, c2, c[2:0]});
            repeat (2) @(negedge clk);
            check("rate1", r1, 20'(c));
            check("rate2", r2, c2);
            check("band1 min", b1lo, bmin[c]);
            check("band1 max", b1hi, bmax[c]);
            check("band2 min", b2lo, bmin[c2]);
            check("band2 max", b2hi, bmax[c2]);
            rd_exp(8'h37, {2'b00, c2, c[2:0]});
        end
        $display("rate bands done");
        // input dividers, input 2 setting spans two bytes
        reset_dut();
        k = $urandom_range(3, 0);
        s = $urandom_range(3, 0);
        i_pdcis_host_model.wr(8'h2d, 8'(k));
        i_pdcis_host_model.wr(8'h2f, 8'h01);
        i_pdcis_host_model.wr(8'h30, 8'(s));
        pulses(3'b010, 3 * (k + 1));
        pulses(3'b100, 2 * (257 + s));
        check("input1 ticks", 20'(n1), 20'h3);
        check("input2 ticks", 20'(n2), 20'h2);
        $display("input dividers done");
        // feedback path: high ratio times low ratio, odd low settings only;
        // input 2 at its zero reset setting runs alongside and passes every tick
        for (int i = 0; i < 2; i++) begin
            reset_dut();
            @(negedge clk);
            fb_upper <= 12'(i);
            fb_high <= 3'($urandom_range(7, 0));
            i_pdcis_host_model.wr(8'h2a, i ? 8'h03 : 8'h01);
            np = 2 * (fb_high + 4) * (i * 256 + (i ? 4 : 2));
            pulses(3'b101, np);
            check("feedback ticks", 20'(nf), 20'h2);
            check("input2 undivided", 20'(n2), 20'(np));
        end
        $display("feedback divider done");
        // active-input flags for every select and alarm combination
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            {los2, los1, sel2, sel1} <= 4'(i);
            @(negedge clk);
            check("active1", act1, i[0] & ~i[2]);
            check("active2", act2, i[1] & ~i[3]);
            rd_exp(8'h80, {6'b001000, i[1] & ~i[3], i[0] & ~i[2]});
        end
        $display("active status done");
        repeat (3) @(negedge clk);
        check("pending reads", 20'(exp_q.size()), 20'h0);
        report_and_stop();
    end
endmodule : tb_pll_divider_config_and_input_status
